// *** bench/fswm_prog_model.sv ***
// programmer model driving the serial test port of the monitor
`timescale 1ns/1ps
module fswm_prog_model (
  // link outputs
  output logic o_lnk_clk,
  output logic o_lnk_sel,
  output logic o_lnk_di,
  // device answer
  input wire logic i_lnk_do
);
  initial begin
    o_lnk_clk = 1'b0;
    o_lnk_sel = 1'b0;
    o_lnk_di = 1'b0;
  end

  // clock stands still between frames; prev collects the last result msb first
  task automatic frame(input logic [31:0] cmd, output logic [31:0] prev);
    prev = 32'h0;
    o_lnk_sel = 1'b1;
    #32;
    for (int i = 31; i >= 0; i--) begin
      o_lnk_di = cmd[i];
      #16;
      prev[i] = i_lnk_do;
      o_lnk_clk = 1'b1;
      #32;
      o_lnk_clk = 1'b0;
      #16;
    end
    o_lnk_sel = 1'b0;
    // released line flips so a stale sample cannot pass
    o_lnk_di = ~o_lnk_di;
    #64;
  endtask
endmodule

// *** bench/tb_flash_security_and_wear_monitor.sv ***
// self-checking bench for the flash security and wear monitor
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_flash_security_and_wear_monitor
  import fswm_pkg::*;
();
  logic i_clk_sys = 1'b0;
  logic i_arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] ecc_s = 4'h0;
  logic [3:0] ecc_d = 4'h0;
  logic [31:0] rdata;
  logic lnk_clk;
  logic lnk_sel;
  logic lnk_di;
  logic lnk_do;
  logic irq;
  logic lnk_oe;
  logic [31:0] last_res = 32'h0;
  logic [31:0] d;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;

  fswm_monitor u_dut (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(rdata),
    .i_lnk_clk(lnk_clk), .i_lnk_sel(lnk_sel), .i_lnk_di(lnk_di), .o_lnk_do(lnk_do),
    .o_lnk_do_oe(lnk_oe), .i_ecc_stat_err(ecc_s), .i_ecc_data_err(ecc_d), .o_irq(irq));
  fswm_prog_model u_prog (.o_lnk_clk(lnk_clk), .o_lnk_sel(lnk_sel), .o_lnk_di(lnk_di),
    .i_lnk_do(lnk_do));

  always #2 i_clk_sys = ~i_clk_sys;

  // 24 frames of about 540 cycles each fit well below this ceiling
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic finish_test;
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge i_clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge i_clk_sys);
    reg_rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  // one frame; the shifted-out word must be the previous result
  task automatic cmd(input fswm_op_t op, input fswm_feat_t f, input logic [1:0] ix,
      input logic [15:0] dat, input logic [3:0] nib);
    fswm_cmd_t c;
    logic [31:0] prev;
    c = '{op: op, feat: f, idx: ix, rsvd: 8'h00, data: dat};
    fork
      u_prog.frame(c, prev);
      begin
        #200;
        `CHK(lnk_oe, 1'b1)
      end
    join
    `CHK(lnk_oe, 1'b0)
    `CHK(prev, last_res)
    bus_rd(OFS_RESULT, last_res);
    `CHK(last_res[31:28], nib)
  endtask

  task automatic t_reset;
    bus_rd(OFS_SEC_CFG, d);
    `CHK(d, 32'h0000_0C00)
    bus_rd(OFS_SEC_STAT, d);
    `CHK(d, 32'h0000_1800)
    bus_rd(8'h20, d);
    `CHK(d, 32'h0000_08F0)
    bus_rd(8'h18, d);
    `CHK(d, 32'h0)
    bus_wr(OFS_PASSKEY, 32'h0000_A5C3);
    bus_rd(OFS_PASSKEY, d);
    `CHK(d, 32'h0)
    $display("test reset done");
  endtask

  task automatic t_wep;
    bus_wr(OFS_SEC_CFG, 32'h0000_0C49);
    bus_wr(OFS_PASSKEY, 32'h0000_A5C3);
    bus_wr(OFS_IRQ_MASK, 32'h0000_0002);
    cmd(OP_PROG, FEAT_FAB, 2'h0, 16'h1234, 4'h4);
    `CHK(irq, 1'b1)
    bus_wr(OFS_IRQ_STAT, 32'h0000_000F);
    `CHK(irq, 1'b0)
    cmd(OP_PROG_ENC, FEAT_FAB, 2'h0, 16'h1234, 4'h4);
    cmd(OP_PROG, FEAT_ROM, 2'h0, 16'h1234, 4'h4);
    cmd(OP_PROG_ENC, FEAT_FLS, 2'h0, 16'h1234, 4'h4);
    cmd(OP_UNLOCK, FEAT_NONE, 2'h0, 16'h0000, 4'h4);
    cmd(OP_UNLOCK, FEAT_NONE, 2'h0, 16'hA5C3, 4'h8);
    bus_rd(OFS_SEC_STAT, d);
    `CHK(d, 32'h0000_1A49)
    cmd(OP_PROG, FEAT_FAB, 2'h0, 16'h1234, 4'h8);
    cmd(OP_PROG_ENC, FEAT_FAB, 2'h0, 16'h1234, 4'h4);
    bus_wr(OFS_IRQ_MASK, 32'h0);
    $display("test write protect done");
  endtask

  task automatic t_read;
    // encryption of rom and flash comes with read protection set
    bus_wr(OFS_SEC_CFG, 32'h0000_0DB2);
    cmd(OP_READ, FEAT_ROM, 2'h0, 16'h0, 4'h4);
    cmd(OP_READ, FEAT_FLS, 2'h0, 16'h0, 4'h4);
    cmd(OP_VERIFY, FEAT_ROM, 2'h0, 16'hFFFF, 4'h4);
    cmd(OP_VERIFY_ENC, FEAT_ROM, 2'h0, 16'hFFFF, 4'hA);
    cmd(OP_VERIFY_ENC, FEAT_FLS, 2'h0, 16'hFFFF, 4'h4);
    cmd(OP_READ, FEAT_FAB, 2'h0, 16'h0, 4'h4);
    cmd(OP_VERIFY, FEAT_FAB, 2'h0, 16'h1234, 4'h4);
    cmd(OP_UNLOCK, FEAT_NONE, 2'h0, 16'hA5C3, 4'h8);
    cmd(OP_READ, FEAT_ROM, 2'h0, 16'h0, 4'h8);
    `CHK(last_res, 32'h8000_FFFF)
    cmd(OP_VERIFY, FEAT_FAB, 2'h0, 16'h1234, 4'hA);
    bus_wr(OFS_SEC_CFG, 32'h0000_0C04);
    cmd(OP_PROG_ENC, FEAT_FAB, 2'h0, 16'h5A5A, 4'h8);
    cmd(OP_VERIFY_ENC, FEAT_FAB, 2'h0, 16'h5A5A, 4'hA);
    $display("test read verify done");
  endtask

  task automatic t_wear;
    cmd(OP_ERASE, FEAT_FLS, 2'h1, 16'h0, 4'h8);
    bus_rd(8'h24, d);
    `CHK(d, 32'h0000_08F1)
    cmd(OP_PROG, FEAT_FLS, 2'h1, 16'h0, 4'h8);
    // threshold multiple zero puts the page past it at once
    bus_wr(OFS_SEC_CFG, 32'h0);
    cmd(OP_PROG, FEAT_FLS, 2'h1, 16'h1234, 4'h9);
    bus_rd(8'h24, d);
    `CHK(d, 32'hC000_08F3)
    cmd(OP_READ, FEAT_FLS, 2'h1, 16'h0, 4'h8);
    `CHK(last_res, 32'h8000_1234)
    bus_rd(8'h20, d);
    `CHK(d, 32'h0000_08F0)
    $display("test wear done");
  endtask

  task automatic t_ecc;
    bus_wr(OFS_IRQ_MASK, 32'h0000_0008);
    @(posedge i_clk_sys);
    ecc_s <= 4'h4;
    ecc_d <= 4'h8;
    @(posedge i_clk_sys);
    ecc_s <= 4'h0;
    ecc_d <= 4'h0;
    bus_rd(8'h28, d);
    `CHK(d, 32'h0002_08F0)
    bus_rd(8'h2C, d);
    `CHK(d, 32'h0001_08F0)
    `CHK(irq, 1'b1)
    bus_wr(OFS_IRQ_STAT, 32'h0000_0008);
    `CHK(irq, 1'b0)
    $display("test ecc done");
  endtask

  initial begin
    repeat (2) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    t_reset();
    t_wep();
    t_read();
    t_wear();
    t_ecc();
    finish_test();
  end
endmodule

// *** core/fswm_monitor.sv ***
// security policy gate and page wear monitor behind a serial test port
// Operation
// - a set write/erase protection flag refuses program or erase of its feature while locked.
// - read protection of the rom area or flash array blocks reads until the passkey is given.
// - fabric verify protection demands the passkey before any fabric verify.
// - fabric contents are never read back; verify compares shifted-in data internally.
// - encrypted programming of a write/erase protected feature is rejected.
// - an unprotected fabric with encryption on takes encrypted program and verify.
// - the rom area always verifies, only by encrypted stream while its encryption flag is set.
// - the flash array never verifies by encrypted stream.
// - every flash page write counter starts at 2288.
// - each program or erase of a page adds exactly one to its counter.
// - the wear threshold is a multiple of 4096, 12288 at reset.
// - program or erase of a page past the threshold drives its status field to 11.
// - each page has a raw status word with separate status and data ecc error flags.
// - a bad counter never blocks programming and cannot be reset by software.
// - the security status word is readable raw.
`timescale 1ns/1ps
module fswm_monitor
  import fswm_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  // register port
  input wire logic [AW-1:0] i_reg_addr,
  input wire logic [DW-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [DW-1:0] o_reg_rdata,
  // test port link
  input wire logic i_lnk_clk,
  input wire logic i_lnk_sel,
  input wire logic i_lnk_di,
  output logic o_lnk_do,
  output logic o_lnk_do_oe,
  // flash ecc detector pulses
  input wire logic [NPAGE-1:0] i_ecc_stat_err,
  input wire logic [NPAGE-1:0] i_ecc_data_err,
  // interrupt
  output logic o_irq
);

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_EXEC} fswm_state_t;

  fswm_state_t state_q, state_d;
  logic [2:0] clk_sy_q, sel_sy_q;
  logic [1:0] di_sy_q;
  logic [FRAME_BITS-1:0] shift_q;
  logic [5:0] bits_q;
  fswm_res_t res_q;
  logic [FRAME_BITS-1:0] out_q;
  logic [CFG_W-1:0] cfg_q;
  logic [15:0] passkey_q;
  logic unlock_q;
  logic [IRQ_W-1:0] irq_stat_q, irq_mask_q;
  logic [DW-1:0] rdata_q;
  logic [15:0] fab_q;
  logic [15:0] rom_q [NROM];
  logic [15:0] fls_q [NPAGE];
  logic [CNT_W-1:0] cnt_q [NPAGE];
  logic [1:0] pst_q [NPAGE];
  logic [NPAGE-1:0] eccs_q, eccd_q;
  logic [DW-1:0] page_word [NPAGE];

  // link edges from the synchronised copies only
  wire clk_rise = clk_sy_q[1] & ~clk_sy_q[2];
  wire clk_fall = ~clk_sy_q[1] & clk_sy_q[2];
  wire sel_on = sel_sy_q[1];
  wire sel_drop = ~sel_sy_q[1] & sel_sy_q[2];
  wire exec = (state_q == ST_EXEC);

  // command decode
  fswm_cmd_t cmd;
  assign cmd = fswm_cmd_t'(shift_q);
  wire is_fab = (cmd.feat == FEAT_FAB);
  wire is_rom = (cmd.feat == FEAT_ROM);
  wire is_fls = (cmd.feat == FEAT_FLS);
  wire no_feat = (cmd.feat == FEAT_NONE);
  wire wep = is_fab ? cfg_q[CFG_FAB_WEP] : is_rom ? cfg_q[CFG_ROM_WEP] : cfg_q[CFG_FLS_WEP];
  wire rdp = is_rom ? cfg_q[CFG_ROM_RP] : is_fls & cfg_q[CFG_FLS_RP];
  wire enc = is_fab ? cfg_q[CFG_FAB_ENC] : is_rom ? cfg_q[CFG_ROM_ENC] : cfg_q[CFG_FLS_ENC];
  wire vfp = is_fab & cfg_q[CFG_FAB_VP] & ~unlock_q;
  wire op_wr = (cmd.op == OP_PROG) | (cmd.op == OP_ERASE);
  wire op_any_wr = op_wr | (cmd.op == OP_PROG_ENC);
  wire op_stor = op_any_wr | (cmd.op == OP_VERIFY) | (cmd.op == OP_VERIFY_ENC)
    | (cmd.op == OP_READ);

  // policy refusals
  wire ref_wr = op_wr & wep & ~unlock_q;
  wire ref_penc = (cmd.op == OP_PROG_ENC) & (wep | ~enc);
  wire ref_ver = (cmd.op == OP_VERIFY) & (vfp | (is_rom & enc));
  wire ref_venc = (cmd.op == OP_VERIFY_ENC) & (is_fls | ~enc | vfp);
  wire ref_rd = (cmd.op == OP_READ) & (is_fab | (rdp & ~unlock_q));
  wire ref_key = (cmd.op == OP_UNLOCK) & (cmd.data != passkey_q);
  wire ref_feat = op_stor & no_feat;
  wire refuse = ref_wr | ref_penc | ref_ver | ref_venc | ref_rd | ref_key | ref_feat;

  // encrypted payloads arrive already decrypted; no cipher lives here
  wire do_wr = exec & ~refuse & op_any_wr;
  wire [15:0] wr_val = (cmd.op == OP_ERASE) ? ERASED_WORD : cmd.data;
  wire [15:0] cur_word = is_fab ? fab_q : is_rom ? rom_q[cmd.idx] : fls_q[cmd.idx];
  wire [CNT_W-1:0] thresh = CNT_W'({cfg_q[CFG_W-1:CFG_THR_LSB], THR_SHIFT'(0)});
  wire worn_now = is_fls & (cnt_q[cmd.idx] > thresh);

  // fabric word leaves only as a match bit, never as data
  fswm_res_t res_d;
  assign res_d.ok = ~refuse;
  assign res_d.refused = refuse;
  assign res_d.match = ~refuse & (cmd.op == OP_VERIFY | cmd.op == OP_VERIFY_ENC)
    & (cur_word == cmd.data);
  assign res_d.wear = do_wr & worn_now;
  assign res_d.rsvd = '0;
  assign res_d.data = (~refuse & (cmd.op == OP_READ)) ? cur_word : 16'h0000;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (sel_on) begin
          state_d = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (sel_drop) begin
          state_d = (bits_q == FRAME_LEN) ? ST_EXEC : ST_IDLE;
        end
      end
      ST_EXEC: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      clk_sy_q <= '0;
      sel_sy_q <= '0;
      di_sy_q <= '0;
      state_q <= ST_IDLE;
    end else begin
      clk_sy_q <= {clk_sy_q[1:0], i_lnk_clk};
      sel_sy_q <= {sel_sy_q[1:0], i_lnk_sel};
      di_sy_q <= {di_sy_q[0], i_lnk_di};
      state_q <= state_d;
    end
  end

  // frame shifter: in on link rise, out on link fall
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      shift_q <= '0;
      bits_q <= '0;
      out_q <= '0;
    end else if (exec) begin
      bits_q <= '0;
      out_q <= res_d;
    end else if (state_q == ST_IDLE) begin
      bits_q <= '0;
    end else if (sel_on & clk_rise & (bits_q != FRAME_LEN)) begin
      shift_q <= {shift_q[FRAME_BITS-2:0], di_sy_q[1]};
      bits_q <= bits_q + 6'h01;
    end else if (sel_on & clk_fall) begin
      out_q <= {out_q[FRAME_BITS-2:0], 1'b0};
    end
  end

  assign o_lnk_do = out_q[FRAME_BITS-1];
  assign o_lnk_do_oe = sel_on;

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      res_q <= '0;
      fab_q <= ERASED_WORD;
    end else if (exec) begin
      res_q <= res_d;
      if (do_wr & is_fab) begin
        fab_q <= wr_val;
      end
    end
  end

  // rom area words
  for (genvar r = 0; r < NROM; r++) begin : g_rom
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
        rom_q[r] <= ERASED_WORD;
      end else if (do_wr & is_rom & (cmd.idx == 2'(r))) begin
        rom_q[r] <= wr_val;
      end
    end
  end

  // flash pages: data, wear counter, status, ecc flags
  for (genvar p = 0; p < NPAGE; p++) begin : g_page
    wire hit = do_wr & is_fls & (cmd.idx == 2'(p));
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
        fls_q[p] <= ERASED_WORD;
        cnt_q[p] <= CNT_START;
        pst_q[p] <= PST_OK;
        eccs_q[p] <= 1'b0;
        eccd_q[p] <= 1'b0;
      end else begin
        if (hit) begin
          fls_q[p] <= wr_val;
          cnt_q[p] <= cnt_q[p] + CNT_W'(1);
        end
        if (hit & worn_now) begin
          pst_q[p] <= PST_WORN;
        end
        if (i_ecc_stat_err[p]) begin
          eccs_q[p] <= 1'b1;
        end
        if (i_ecc_data_err[p]) begin
          eccd_q[p] <= 1'b1;
        end
      end
    end
    assign page_word[p] = {pst_q[p], 12'h000, eccs_q[p], eccd_q[p], 2'h0, cnt_q[p]};
  end

  // register port decode
  wire sel_cfg = (i_reg_addr == OFS_SEC_CFG);
  wire sel_key = (i_reg_addr == OFS_PASSKEY);
  wire sel_sst = (i_reg_addr == OFS_SEC_STAT);
  wire sel_ist = (i_reg_addr == OFS_IRQ_STAT);
  wire sel_msk = (i_reg_addr == OFS_IRQ_MASK);
  wire sel_res = (i_reg_addr == OFS_RESULT);
  wire sel_pg = (i_reg_addr[7:4] == OFS_PAGE_HI);
  wire [1:0] pg_idx = i_reg_addr[3:2];
  wire [DW-1:0] sec_word = DW'({cfg_q[CFG_W-1:CFG_THR_LSB], 1'b0, unlock_q,
    cfg_q[CFG_FLS_ENC:0]});
  wire [DW-1:0] rd_mux = sel_cfg ? DW'(cfg_q) : sel_sst ? sec_word
    : sel_ist ? DW'(irq_stat_q) : sel_msk ? DW'(irq_mask_q)
    : sel_res ? res_q : sel_pg ? page_word[pg_idx] : '0;

  // events; a set in the clearing cycle wins
  wire [IRQ_W-1:0] irq_ev = {|(i_ecc_stat_err | i_ecc_data_err),
    res_d.wear & exec, refuse & exec, ~refuse & exec};
  wire [IRQ_W-1:0] irq_clr = (i_reg_wr & sel_ist) ? i_reg_wdata[IRQ_W-1:0] : '0;

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg_q <= CFG_RST;
      passkey_q <= PASSKEY_RST;
      irq_mask_q <= '0;
      irq_stat_q <= '0;
      rdata_q <= '0;
    end else begin
      if (i_reg_wr & sel_cfg) begin
        cfg_q <= i_reg_wdata[CFG_W-1:0];
      end
      if (i_reg_wr & sel_key) begin
        passkey_q <= i_reg_wdata[15:0];
      end
      if (i_reg_wr & sel_msk) begin
        irq_mask_q <= i_reg_wdata[IRQ_W-1:0];
      end
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
      rdata_q <= i_reg_rd ? rd_mux : '0;
    end
  end

  // unlock lasts until lock op or any key/config write
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      unlock_q <= 1'b0;
    end else if (i_reg_wr & (sel_key | sel_cfg)) begin
      unlock_q <= 1'b0;
    end else if (exec & (cmd.op == OP_LOCK)) begin
      unlock_q <= 1'b0;
    end else if (exec & (cmd.op == OP_UNLOCK) & ~ref_key) begin
      unlock_q <= 1'b1;
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_irq = |(irq_stat_q & irq_mask_q);

  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  sequence s_op(fswm_op_t o, fswm_feat_t f);
    exec && cmd.op == o && cmd.feat == f;
  endsequence

  a_wep_refuse: assert property (
    s_op(OP_PROG, FEAT_ROM) and (cfg_q[CFG_ROM_WEP] && !unlock_q) |=> res_q.refused)
    else $error("protected rom program accepted");
  a_read_lock: assert property (
    s_op(OP_READ, FEAT_FLS) and (cfg_q[CFG_FLS_RP] && !unlock_q)
      |=> res_q.refused && res_q.data == 16'h0000)
    else $error("protected flash read leaked");
  a_verify_lock: assert property (
    s_op(OP_VERIFY, FEAT_FAB) and (cfg_q[CFG_FAB_VP] && !unlock_q) |=> !res_q.match)
    else $error("fabric verify without passkey");
  a_no_fab_read: assert property (
    s_op(OP_READ, FEAT_FAB) |=> res_q.refused ##1 1)
    else $error("fabric readback allowed");
  a_enc_reject: assert property (
    s_op(OP_PROG_ENC, FEAT_FLS) and cfg_q[CFG_FLS_WEP] |=> res_q.refused)
    else $error("encrypted program of protected flash");
  a_fab_enc_ok: assert property (
    s_op(OP_VERIFY_ENC, FEAT_FAB)
      and (cfg_q[CFG_FAB_ENC] && !cfg_q[CFG_FAB_VP]) |=> res_q.ok)
    else $error("fabric encrypted verify refused");
  a_rom_enc_ver: assert property (
    s_op(OP_VERIFY, FEAT_ROM) |=> res_q.refused == $past(cfg_q[CFG_ROM_ENC]))
    else $error("rom verify policy wrong");
  a_fls_enc_ver: assert property (
    s_op(OP_VERIFY_ENC, FEAT_FLS) |=> res_q.refused)
    else $error("flash encrypted verify allowed");
  a_cnt_step: assert property (
    g_page[1].hit |=> cnt_q[1] == $past(cnt_q[1]) + CNT_W'(1) ##1 cnt_q[1] >= CNT_START)
    else $error("page counter step wrong");
  a_wear_stat: assert property (
    g_page[1].hit && cnt_q[1] > thresh |=> pst_q[1] == PST_WORN && res_q.wear)
    else $error("worn page status not set");
  a_irq_level: assert property (
    (irq_ev & irq_mask_q) != '0 && !(i_reg_wr && sel_msk) |=> o_irq)
    else $error("interrupt not raised");

  // a full frame runs exactly once, a cycle after select drops
  sequence s_full_frame;
    state_q == ST_SHIFT && sel_drop && bits_q == FRAME_LEN;
  endsequence
  sequence s_one_exec;
    exec ##1 !exec;
  endsequence
  a_frame_exec: assert property (
    s_full_frame |=> s_one_exec)
    else $error("full frame not executed");

  // fixed pages keep the wear and ecc properties small
  a_rom_read_lock: assert property (
    s_op(OP_READ, FEAT_ROM) and (cfg_q[CFG_ROM_RP] && !unlock_q)
      |=> res_q.refused && res_q.data == 16'h0000)
    else $error("protected rom read leaked");
  a_fab_enc_prog: assert property (
    s_op(OP_PROG_ENC, FEAT_FAB) and (cfg_q[CFG_FAB_ENC] && !cfg_q[CFG_FAB_WEP])
      |=> res_q.ok && fab_q == $past(cmd.data))
    else $error("fabric encrypted program refused");
  a_rom_enc_ok: assert property (
    s_op(OP_VERIFY_ENC, FEAT_ROM) and cfg_q[CFG_ROM_ENC] |=> res_q.ok)
    else $error("rom encrypted verify refused");
  a_key_unlock: assert property (
    s_op(OP_PROG, FEAT_FAB) and (cfg_q[CFG_FAB_WEP] && unlock_q) |=> res_q.ok)
    else $error("unlocked fabric program refused");
  a_enc_unlocked: assert property (
    s_op(OP_PROG_ENC, FEAT_FAB) and (cfg_q[CFG_FAB_WEP] && unlock_q) |=> res_q.refused)
    else $error("encrypted program of protected fabric");
  a_worn_prog: assert property (
    s_op(OP_PROG, FEAT_FLS) and (!cfg_q[CFG_FLS_WEP] && cmd.idx == 2'h1
      && cnt_q[1] > thresh) |=> res_q.ok && fls_q[1] == $past(cmd.data))
    else $error("worn page program blocked");
  a_ecc_status: assert property (
    i_ecc_stat_err[2] |=> page_word[2][PST_ECCS])
    else $error("status ecc flag missing");
  a_ecc_data: assert property (
    i_ecc_data_err[3] |=> page_word[3][PST_ECCD])
    else $error("data ecc flag missing");
  a_worn_sticky: assert property (
    pst_q[1] == PST_WORN |=> page_word[1][PST_LSB+1:PST_LSB] == PST_WORN)
    else $error("worn status lost");
  a_sec_raw: assert property (
    i_reg_rd && sel_sst |=> o_reg_rdata[CFG_FLS_ENC:0] == $past(cfg_q[CFG_FLS_ENC:0])
      && o_reg_rdata[STAT_UNLOCK] == $past(unlock_q))
    else $error("security word not raw");

endmodule

// *** core/fswm_pkg.sv ***
// shared constants and carriers for the flash security and wear monitor
package fswm_pkg;
  // register bus
  localparam int AW = 8;
  localparam int DW = 32;
  localparam logic [7:0] OFS_SEC_CFG = 8'h00;
  localparam logic [7:0] OFS_PASSKEY = 8'h04;
  localparam logic [7:0] OFS_SEC_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_RESULT = 8'h14;
  localparam logic [3:0] OFS_PAGE_HI = 4'h2;
  // security configuration bits
  localparam int CFG_FAB_WEP = 0;
  localparam int CFG_FAB_VP = 1;
  localparam int CFG_FAB_ENC = 2;
  localparam int CFG_ROM_WEP = 3;
  localparam int CFG_ROM_RP = 4;
  localparam int CFG_ROM_ENC = 5;
  localparam int CFG_FLS_WEP = 6;
  localparam int CFG_FLS_RP = 7;
  localparam int CFG_FLS_ENC = 8;
  localparam int STAT_UNLOCK = 9;
  localparam int CFG_THR_LSB = 10;
  localparam int CFG_W = 12;
  localparam logic [11:0] CFG_RST = 12'hC00;
  localparam logic [15:0] PASSKEY_RST = 16'h0000;
  // storage and wear
  localparam int NPAGE = 4;
  localparam int NROM = 4;
  localparam int CNT_W = 14;
  localparam logic [13:0] CNT_START = 14'h08F0;
  localparam int THR_SHIFT = 12;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [1:0] PST_OK = 2'h0;
  localparam logic [1:0] PST_WORN = 2'h3;
  localparam int PST_LSB = 30;
  localparam int PST_ECCS = 17;
  localparam int PST_ECCD = 16;
  // interrupt bits
  localparam int IRQ_W = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_REFUSED = 1;
  localparam int IRQ_WEAR = 2;
  localparam int IRQ_ECC = 3;
  // link frame
  localparam int FRAME_BITS = 32;
  localparam logic [5:0] FRAME_LEN = 6'h20;

  typedef enum logic [3:0] {
    OP_NOP, OP_PROG, OP_ERASE, OP_PROG_ENC, OP_VERIFY,
    OP_VERIFY_ENC, OP_READ, OP_UNLOCK, OP_LOCK
  } fswm_op_t;

  typedef enum logic [1:0] {FEAT_FAB, FEAT_ROM, FEAT_FLS, FEAT_NONE} fswm_feat_t;

  typedef struct packed {
    fswm_op_t op;
    fswm_feat_t feat;
    logic [1:0] idx;
    logic [7:0] rsvd;
    logic [15:0] data;
  } fswm_cmd_t;

  typedef struct packed {
    logic ok;
    logic refused;
    logic match;
    logic wear;
    logic [11:0] rsvd;
    logic [15:0] data;
  } fswm_res_t;
endpackage
